// >>> bench/boundary_scan_test_access_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
module boundary_scan_test_access_port_bench;
  import scan_port_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic test_nrst = 1'b1;
  logic tck, tms, tdi, tdo, oe_n, in_rst, t, e;
  logic [3:0] instr, d;
  int bad_count = 0;
  int n_tests = 0;
  int seed = 21322;
  int cycles = 0;
  always #50 clk = ~clk;
  scan_port scan_port_inst (.i_clk(clk), .i_nrst(nrst), .i_tck(tck),
    .i_tms(tms), .i_tdi(tdi), .i_test_nrst(test_nrst), .o_tdo(tdo),
    .o_tdo_oe_n(oe_n), .o_instr(instr), .o_in_reset(in_rst));
  scan_tester scan_tester_inst (.i_clk(clk), .i_tdo(tdo),
    .i_tdo_oe_n(oe_n), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [3:0] exp,
    input logic [3:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Mode-select bits LSB first, random serial data; slack for the sync delay
  task automatic walk(input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++)
      scan_tester_inst.bit_step(m[i], 1'($random(seed)), t, e);
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk("in_reset", 4'h1, {3'h0, in_rst});
    chk("instr", IR_RESET, instr);
    for (int k = 0; k < 6; k++)
    begin
      d = 4'($random(seed));
      walk(8'h06, 5);
      chk("in_reset", 4'h0, {3'h0, in_rst});
      for (int i = 0; i < 4; i++)
      begin
        scan_tester_inst.bit_step(i == 3, d[i], t, e);
        chk("tdo", {3'h0, IR_CAPTURE[i]}, {3'h0, t});
        chk("oe_n", 4'h0, {3'h0, e});
      end
      scan_tester_inst.bit_step(1'b1, 1'b0, t, e);
      chk("oe_n", 4'h1, {3'h0, e});
      walk(8'h00, 1);
      chk("instr", d, instr);
    end
    walk(8'h01, 3);
    scan_tester_inst.bit_step(1'b0, 1'b1, t, e);
    chk("bypass tdo", 4'h0, {3'h0, t});
    scan_tester_inst.bit_step(1'b0, 1'b0, t, e);
    chk("bypass tdo", 4'h1, {3'h0, t});
    walk(8'h0F, 4);
    chk("in_reset", 4'h0, {3'h0, in_rst});
    walk(8'h01, 1);
    chk("in_reset", 4'h1, {3'h0, in_rst});
    walk(8'h00, 1);
    // Asynchronous reset must land before the next clock edge
    test_nrst <= 1'b0;
    #20;
    chk("in_reset", 4'h1, {3'h0, in_rst});
    chk("instr", IR_RESET, instr);
    @(posedge clk);
    test_nrst <= 1'b1;
    // Controller must run again once test reset is let go
    walk(8'h00, 1);
    chk("in_reset", 4'h0, {3'h0, in_rst});
    chk("instr", IR_RESET, instr);
    conclude();
  end
endmodule
`default_nettype wire

// >>> bench/scan_tester.sv
`timescale 1ns/10ps
`default_nettype none
module scan_tester (
  input wire logic i_clk,
  input wire logic i_tdo,
  input wire logic i_tdo_oe_n,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  // Test clock stands low between frames
  initial o_tck = 1'b0;
  initial o_tms = 1'b1;
  initial o_tdi = 1'b1;
  ////////////////////////////////////////////////////////////////////////////
  // One 800 ns test-clock period; tdo read just before the falling edge,
  // where the value launched by the last falling edge is surely settled
  task automatic bit_step(input logic tms, input logic tdi,
    output logic tdo, output logic oe_n);
    o_tms <= tms;
    o_tdi <= tdi;
    repeat (4) @(posedge i_clk);
    o_tck <= 1'b1;
    repeat (4) @(posedge i_clk);
    // No pull on the line: a released output reads as the inverse
    tdo = i_tdo_oe_n ? ~i_tdo : i_tdo;
    oe_n = i_tdo_oe_n;
    o_tck <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> rtl/scan_port.sv
`timescale 1ns/10ps
`default_nettype none

// Contract
// - The tester supplies the test clock and, apart from reset, only its edges move scan state and serial data.
// - Serial input is shifted in on each rising test-clock edge while in a shift state.
// - Serial output changes on each falling test-clock edge while in a shift state.
// - Mode select sampled at each rising test-clock edge chooses the next state.
// - Asserting test reset puts the controller in test-logic-reset at once.
// - The serial output floats except from a falling edge in shift-DR or shift-IR until the next falling edge in any other state.
module scan_port
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic i_test_nrst,
  output logic o_tdo,
  output logic o_tdo_oe_n,
  output logic [scan_port_pkg::IR_WIDTH-1:0] o_instr,
  output logic o_in_reset
);
  import scan_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; test reset also acts asynchronously
  scan_pins_t sync1;
  scan_pins_t sync2;
  logic tck_prev;
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      sync1 <= '0;
      sync2 <= '0;
      tck_prev <= 1'b0;
    end
    else
    begin
      sync1 <= '{tck: i_tck, tms: i_tms, tdi: i_tdi};
      sync2 <= sync1;
      tck_prev <= sync2.tck;
    end
  end

  logic tck_rise;
  logic tck_fall;
  assign tck_rise = sync2.tck & ~tck_prev;
  assign tck_fall = ~sync2.tck & tck_prev;

  // Reset asserts at once but releases through two flops, so a late
  // test-reset edge cannot leave half the controller in reset
  logic rst_raw_n;
  logic [1:0] rst_sync;
  logic arst_n;
  assign rst_raw_n = i_nrst & i_test_nrst;
  always_ff @(posedge i_clk or negedge rst_raw_n)
  begin
    if (!rst_raw_n)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'h1};
  end
  assign arst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // Controller
  tap_state_t state;
  tap_state_t next_state;
  logic in_reset;
  logic next_in_reset;

  function automatic tap_state_t step(input tap_state_t s, input logic m);
    unique case (s)
      ST_RESET: step = m ? ST_RESET : ST_IDLE;
      ST_IDLE: step = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: step = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: step = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: step = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: step = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: step = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: step = m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: step = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: step = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: step = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: step = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: step = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: step = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: step = m ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: step = m ? ST_SEL_DR : ST_IDLE;
      default: step = ST_RESET;
    endcase
  endfunction

  always_comb
  begin
    next_state = state;
    if (tck_rise)
      next_state = step(state, sync2.tms);
    next_in_reset = (next_state == ST_RESET);
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift paths
  logic [IR_WIDTH-1:0] ir_shift;
  logic [IR_WIDTH-1:0] next_ir_shift;
  logic [IR_WIDTH-1:0] instr;
  logic [IR_WIDTH-1:0] next_instr;
  logic [DR_WIDTH-1:0] dr_shift;
  logic [DR_WIDTH-1:0] next_dr_shift;
  logic tdo;
  logic next_tdo;
  logic tdo_oe_n;
  logic next_tdo_oe_n;
  logic shifting;
  assign shifting = (state == ST_SHIFT_DR) || (state == ST_SHIFT_IR);

  always_comb
  begin
    next_ir_shift = ir_shift;
    next_instr = instr;
    next_dr_shift = dr_shift;
    next_tdo = tdo;
    next_tdo_oe_n = tdo_oe_n;
    if (tck_rise)
    begin
      unique case (state)
        ST_CAP_IR: next_ir_shift = IR_CAPTURE;
        ST_SHIFT_IR: next_ir_shift = {sync2.tdi, ir_shift[IR_WIDTH-1:1]};
        ST_CAP_DR: next_dr_shift = '0;
        ST_SHIFT_DR: next_dr_shift = sync2.tdi;
        ST_UPD_IR: next_instr = ir_shift;
        default: next_instr = instr;
      endcase
    end
    if (state == ST_RESET)
      next_instr = IR_RESET;
    if (tck_fall)
    begin
      next_tdo_oe_n = ~shifting;
      if (state == ST_SHIFT_IR)
        next_tdo = ir_shift[0];
      else if (state == ST_SHIFT_DR)
        next_tdo = dr_shift[0];
    end
  end

  always_ff @(posedge i_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_RESET;
      in_reset <= 1'b1;
      ir_shift <= '0;
      instr <= IR_RESET;
      dr_shift <= '0;
      tdo <= 1'b0;
      tdo_oe_n <= 1'b1;
    end
    else
    begin
      state <= next_state;
      in_reset <= next_in_reset;
      ir_shift <= next_ir_shift;
      instr <= next_instr;
      dr_shift <= next_dr_shift;
      tdo <= next_tdo;
      tdo_oe_n <= next_tdo_oe_n;
    end
  end

  assign o_tdo = tdo;
  assign o_tdo_oe_n = tdo_oe_n;
  assign o_instr = instr;
  assign o_in_reset = in_reset;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  logic [2:0] high_cnt;
  always_ff @(posedge i_clk or negedge arst_n)
  begin
    if (!arst_n)
      high_cnt <= '0;
    else if (tck_rise)
      high_cnt <= sync2.tms ? ((high_cnt == 3'h7) ? high_cnt
                                                  : high_cnt + 3'h1) : 3'h0;
  end

  property p_five_high;
    @(posedge i_clk) disable iff (!arst_n)
      (high_cnt >= 3'(RESET_TMS_EDGES)) |-> (state == ST_RESET);
  endproperty
  a_five_high: assert property (p_five_high)
    else $error("controller not reset after five high edges");

  property p_float;
    @(posedge i_clk) disable iff (!arst_n)
      (tck_fall && !shifting) |=> tdo_oe_n;
  endproperty
  a_float: assert property (p_float)
    else $error("serial output driven outside shift");

  sequence s_fall_in_shift;
    tck_fall && shifting;
  endsequence
  property p_drive;
    @(posedge i_clk) disable iff (!arst_n)
      s_fall_in_shift |=> !tdo_oe_n;
  endproperty
  a_drive: assert property (p_drive)
    else $error("serial output not driven in shift");

  property p_hold;
    @(posedge i_clk) disable iff (!arst_n)
      !tck_rise |=> $stable(state);
  endproperty
  a_hold: assert property (p_hold)
    else $error("state moved without rising edge");

  property p_idle_stay;
    @(posedge i_clk) disable iff (!arst_n)
      (tck_rise && state == ST_IDLE && !sync2.tms) |=> state == ST_IDLE;
  endproperty
  a_idle_stay: assert property (p_idle_stay)
    else $error("idle left with low mode select");

  property p_ir_shift;
    @(posedge i_clk) disable iff (!arst_n)
      (tck_rise && state == ST_SHIFT_IR)
        |=> ir_shift[IR_WIDTH-1] == $past(sync2.tdi);
  endproperty
  a_ir_shift: assert property (p_ir_shift)
    else $error("serial input not shifted into instruction");

  property p_tdo;
    @(posedge i_clk) disable iff (!arst_n)
      (tck_fall && state == ST_SHIFT_IR) |=> tdo == $past(ir_shift[0]);
  endproperty
  a_tdo: assert property (p_tdo)
    else $error("serial output not updated on falling edge");

  property p_tdo_stable;
    @(posedge i_clk) disable iff (!arst_n)
      !tck_fall |=> $stable(tdo);
  endproperty
  a_tdo_stable: assert property (p_tdo_stable)
    else $error("serial output changed off a falling edge");

  property p_onehot;
    @(posedge i_clk) disable iff (!arst_n)
      $onehot(state);
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("controller state not one-hot");

endmodule

`default_nettype wire

// >>> rtl/scan_port_pkg.sv
package scan_port_pkg;

  // Controller states, one-hot
  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPD_DR     = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPD_IR     = 16'h8000
  } tap_state_t;

  localparam int IR_WIDTH = 4;
  localparam int DR_WIDTH = 1;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_RESET = 4'hF;
  localparam logic [3:0] IR_BYPASS = 4'hF;
  localparam int RESET_TMS_EDGES = 5;

  // Synchronised scan pins travelling together
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } scan_pins_t;

endpackage
